// File: rtl/flash_block_program_sequencer.sv
// Flash block program sequencer with holding registers and unlock guard
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_block_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int FLASH_BYTES  = 8192,
  parameter int EE_BYTES     = 256,
  parameter int WRITE_CYCLES = `LONG_WRITE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       master_clear_pin,
  input  wire logic       watchdog_expiry,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            cpu_stall,
  output logic            memory_done_flag
);
  // Address widths of the two arrays
  localparam int FA = $clog2(FLASH_BYTES);
  localparam int EA = $clog2(EE_BYTES);

  reg_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Storage arrays
  logic [7:0] flash_mem [FLASH_BYTES];
  logic [7:0] ee_mem    [EE_BYTES];
  logic [7:0] hold_reg  [8];

  logic [21:0]   table_pointer_reg;
  logic [7:0]    table_byte_latch_reg;
  logic [7:0]    interrupt_control_reg;
  logic [7:0]    nvm_control_reg;
  logic [7:0]    peripheral_priority_two_reg;
  logic [7:0]    peripheral_flags_two_reg;
  logic [7:0]    peripheral_enables_two_reg;
  logic [7:0]    eeprom_byte_value_reg;
  logic [7:0]    eeprom_location_reg;
  logic [7:0]    rdata_reg;
  logic          stall_reg;
  logic [31:0]   timer_reg;
  unlock_state_t lock_reg;
  op_state_t     op_reg;
  logic [1:0]    master_clear_pin_sync_reg;
  logic [1:0]    wdt_sync_reg;

  // Decode
  wire hit_unlock  = req.addr == `ADDR_UNLOCK;
  wire hit_ctrl    = req.addr == `ADDR_NVM_CONTROL;
  wire wr_unlock   = req.wr && hit_unlock;
  wire wr_ctrl     = req.wr && hit_ctrl;
  wire busy        = op_reg != OP_IDLE;
  wire go_req      = wr_ctrl && req.wdata[`BIT_GO];
  // Program enable must be set beforehand, not in the same write
  wire go_allowed  = go_req && nvm_control_reg[`BIT_PROG_EN]
                     && lock_reg == LOCK_OPEN && !busy;
  wire start_flash = go_allowed && nvm_control_reg[`BIT_FLASH_SEL]
                     && !nvm_control_reg[`BIT_CFG_SEL];
  wire start_ee    = go_allowed && !nvm_control_reg[`BIT_FLASH_SEL]
                     && !nvm_control_reg[`BIT_CFG_SEL];
  wire timer_done  = busy && timer_reg == 32'h0000_0001;
  wire ext_reset   = master_clear_pin_sync_reg[1] || wdt_sync_reg[1];
  // EEPROM read acts at once; the read bit is never stored
  wire ee_read     = wr_ctrl && req.wdata[`BIT_READ] && !busy
                     && !req.wdata[`BIT_FLASH_SEL]
                     && !req.wdata[`BIT_CFG_SEL];
  wire store_op    = req.wr && req.addr == `ADDR_STORE_OP && !busy;
  wire fetch_op    = req.wr && req.addr == `ADDR_FETCH_OP;
  wire prog_done   = timer_done && op_reg == OP_FLASH_PROG;
  wire erase_sel   = nvm_control_reg[`BIT_ROW_ERASE];
  // Row and block bases inside the flash array
  wire [FA-1:0] row_base  = {table_pointer_reg[FA-1:6], 6'h00};
  wire [FA-1:0] blk_base  = {table_pointer_reg[FA-1:3], 3'h0};
  wire [2:0]    hold_sel  = table_pointer_reg[2:0];
  wire [EA-1:0] ee_addr   = eeprom_location_reg[EA-1:0];

  // Write strobe aimed at one register address
  function automatic logic wr_hit(input reg_req_t   r,
                                  input logic [7:0] a);
    wr_hit = r.wr && r.addr == a;
  endfunction

  wire wr_ptr_upper   = wr_hit(req, `ADDR_PTR_UPPER);
  wire wr_ptr_high    = wr_hit(req, `ADDR_PTR_HIGH);
  wire wr_ptr_low     = wr_hit(req, `ADDR_PTR_LOW);
  wire wr_latch       = wr_hit(req, `ADDR_BYTE_LATCH);
  wire wr_irq         = wr_hit(req, `ADDR_IRQ_CONTROL);
  wire wr_prio        = wr_hit(req, `ADDR_PRIO_TWO);
  wire wr_flags       = wr_hit(req, `ADDR_FLAGS_TWO);
  wire wr_enables     = wr_hit(req, `ADDR_ENABLES_TWO);
  wire wr_ee_value    = wr_hit(req, `ADDR_EE_VALUE) && !busy;
  wire wr_ee_loc      = wr_hit(req, `ADDR_EE_LOCATION) && !busy;
  wire sw_clears_done = wr_flags && !req.wdata[`BIT_DONE_FLAG];

  // Control register write keeps go and interrupted flag hardware-owned
  wire [7:0] ctrl_next =
    (req.wdata & `CTRL_MASK & 8'hF4)
    | (nvm_control_reg & 8'h0A);

  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    if (req.addr == `ADDR_PTR_UPPER) begin
      rdata_next = {2'b00, table_pointer_reg[21:16]};
    end else if (req.addr == `ADDR_PTR_HIGH) begin
      rdata_next = table_pointer_reg[15:8];
    end else if (req.addr == `ADDR_PTR_LOW) begin
      rdata_next = table_pointer_reg[7:0];
    end else if (req.addr == `ADDR_BYTE_LATCH) begin
      rdata_next = table_byte_latch_reg;
    end else if (req.addr == `ADDR_IRQ_CONTROL) begin
      rdata_next = interrupt_control_reg;
    end else if (req.addr == `ADDR_NVM_CONTROL) begin
      rdata_next = nvm_control_reg;
    end else if (req.addr == `ADDR_PRIO_TWO) begin
      rdata_next = peripheral_priority_two_reg;
    end else if (req.addr == `ADDR_FLAGS_TWO) begin
      rdata_next = peripheral_flags_two_reg;
    end else if (req.addr == `ADDR_ENABLES_TWO) begin
      rdata_next = peripheral_enables_two_reg;
    end else if (req.addr == `ADDR_EE_VALUE) begin
      rdata_next = eeprom_byte_value_reg;
    end else if (req.addr == `ADDR_EE_LOCATION) begin
      rdata_next = eeprom_location_reg;
    end else if (req.addr == `ADDR_STATUS) begin
      rdata_next = {6'h00, lock_reg == LOCK_OPEN, busy};
    end else begin
      rdata_next = 8'h00;
    end
  end

  // Program only clears bits; FFh holding byte keeps the flash byte
  function automatic logic [7:0] prog_byte(input logic [7:0] old,
                                           input logic [7:0] hold);
    prog_byte = old & hold;
  endfunction

  // Two-stage synchronisers for the external reset events
  always_ff @(posedge clock) begin
    master_clear_pin_sync_reg <= {master_clear_pin_sync_reg[0], master_clear_pin};
    wdt_sync_reg  <= {wdt_sync_reg[0], watchdog_expiry};
  end

  // Unlock sequence tracker; any other bus write breaks the sequence
  always_ff @(posedge clock) begin
    if (srst || ext_reset) begin
      lock_reg <= LOCK_IDLE;
    end else if (req.wr) begin
      case (lock_reg)
        LOCK_IDLE: begin
          lock_reg <= (wr_unlock && req.wdata == `UNLOCK_FIRST)
                      ? LOCK_GOT_FIRST : LOCK_IDLE;
        end
        LOCK_GOT_FIRST: begin
          lock_reg <= (wr_unlock && req.wdata == `UNLOCK_SECOND)
                      ? LOCK_OPEN : LOCK_IDLE;
        end
        default: begin
          lock_reg <= LOCK_IDLE;
        end
      endcase
    end
  end

  // Self-timed long write
  always_ff @(posedge clock) begin
    if (srst || ext_reset) begin
      op_reg    <= OP_IDLE;
      timer_reg <= 32'h0;
      stall_reg <= 1'b0;
    end else if (start_flash) begin
      op_reg    <= OP_FLASH_PROG;
      timer_reg <= 32'(WRITE_CYCLES);
      stall_reg <= 1'b1;
    end else if (start_ee) begin
      op_reg    <= OP_EE_WRITE;
      timer_reg <= 32'(WRITE_CYCLES);
    end else if (timer_done) begin
      op_reg    <= OP_IDLE;
      timer_reg <= 32'h0;
      stall_reg <= 1'b0;
    end else if (busy) begin
      timer_reg <= timer_reg - 32'h1;
    end
  end

  // Array updates at completion; whole row or block at once
  always_ff @(posedge clock) begin
    if (prog_done && erase_sel) begin
      for (int i = 0; i < `ROW_BYTES; i++) begin
        flash_mem[row_base + FA'(i)] <= `ERASED_BYTE;
      end
    end else if (prog_done) begin
      for (int i = 0; i < 8; i++) begin
        flash_mem[blk_base + FA'(i)] <=
          prog_byte(flash_mem[blk_base + FA'(i)], hold_reg[i]);
      end
    end
    if (timer_done && op_reg == OP_EE_WRITE) begin
      ee_mem[ee_addr] <= eeprom_byte_value_reg;
    end
  end

  // Holding registers
  always_ff @(posedge clock) begin
    if (srst || ext_reset
        || (timer_done && op_reg == OP_FLASH_PROG)) begin
      for (int i = 0; i < 8; i++) begin
        hold_reg[i] <= `HOLD_RESET;
      end
    end else if (store_op) begin
      hold_reg[hold_sel] <= table_byte_latch_reg;
    end
  end

  // Table pointer; an external reset blocks software writes
  always_ff @(posedge clock) begin
    if (srst) begin
      table_pointer_reg <= 22'h0;
    end else if (!ext_reset) begin
      if (wr_ptr_upper) begin
        table_pointer_reg[21:16] <= req.wdata[5:0];
      end
      if (wr_ptr_high) begin
        table_pointer_reg[15:8] <= req.wdata;
      end
      if (wr_ptr_low) begin
        table_pointer_reg[7:0] <= req.wdata;
      end
    end
  end

  // Table latch: software value or byte fetched from the array
  always_ff @(posedge clock) begin
    if (srst) begin
      table_byte_latch_reg <= 8'h00;
    end else if (wr_latch && !ext_reset) begin
      table_byte_latch_reg <= req.wdata;
    end else if (fetch_op && !ext_reset) begin
      table_byte_latch_reg <= flash_mem[table_pointer_reg[FA-1:0]];
    end
  end

  // Plain read-write neighbours of the control registers
  always_ff @(posedge clock) begin
    if (srst) begin
      interrupt_control_reg       <= 8'h00;
      peripheral_priority_two_reg <= `PRIO_RESET;
      peripheral_enables_two_reg  <= 8'h00;
    end else if (!ext_reset) begin
      if (wr_irq) begin
        interrupt_control_reg <= req.wdata;
      end
      if (wr_prio) begin
        peripheral_priority_two_reg <= req.wdata;
      end
      if (wr_enables) begin
        peripheral_enables_two_reg <= req.wdata;
      end
    end
  end

  // EEPROM value and location, frozen while a write runs
  always_ff @(posedge clock) begin
    if (srst) begin
      eeprom_byte_value_reg <= 8'h00;
      eeprom_location_reg   <= 8'h00;
    end else if (!ext_reset) begin
      if (wr_ee_loc) begin
        eeprom_location_reg <= req.wdata;
      end
      if (ee_read) begin
        eeprom_byte_value_reg <= ee_mem[ee_addr];
      end else if (wr_ee_value) begin
        eeprom_byte_value_reg <= req.wdata;
      end
    end
  end

  // Flag register: set by completion wins over software clear
  always_ff @(posedge clock) begin
    if (srst) begin
      peripheral_flags_two_reg <= 8'h00;
      memory_done_flag         <= 1'b0;
    end else if (!ext_reset) begin
      if (wr_flags) begin
        peripheral_flags_two_reg <= req.wdata;
      end
      if (timer_done) begin
        peripheral_flags_two_reg[`BIT_DONE_FLAG] <= 1'b1;
      end
      memory_done_flag <= timer_done
        || (peripheral_flags_two_reg[`BIT_DONE_FLAG] && !sw_clears_done);
    end
  end

  // Control register; an external reset aborts and leaves a trace
  always_ff @(posedge clock) begin
    if (srst) begin
      nvm_control_reg <= 8'h00;
    end else if (ext_reset) begin
      nvm_control_reg[`BIT_PROG_EN] <= 1'b0;
      nvm_control_reg[`BIT_GO]      <= 1'b0;
      nvm_control_reg[`BIT_READ]    <= 1'b0;
      if (busy) begin
        nvm_control_reg[`BIT_INTERRUPTED] <= 1'b1;
      end
    end else begin
      // Locked while a write runs
      if (wr_ctrl && !busy) begin
        nvm_control_reg <= ctrl_next;
        if (go_allowed) begin
          nvm_control_reg[`BIT_GO]          <= 1'b1;
          nvm_control_reg[`BIT_INTERRUPTED] <= 1'b1;
        end
      end
      // Completion hands go and the error trace back
      if (timer_done) begin
        nvm_control_reg[`BIT_GO]          <= 1'b0;
        nvm_control_reg[`BIT_INTERRUPTED] <= 1'b0;
        nvm_control_reg[`BIT_ROW_ERASE]   <= 1'b0;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= req.rd ? rdata_next : 8'h00;
    end
  end

  // Outputs straight from flip-flops
  assign rdata     = rdata_reg;
  assign cpu_stall = stall_reg;
endmodule

// File: rtl/flash_seq_params.svh
// Register offsets, reset values and timing counts for the flash sequencer
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define ADDR_PTR_UPPER    8'h00
`define ADDR_PTR_HIGH     8'h01
`define ADDR_PTR_LOW      8'h02
`define ADDR_BYTE_LATCH   8'h03
`define ADDR_IRQ_CONTROL  8'h04
`define ADDR_UNLOCK       8'h05
`define ADDR_NVM_CONTROL  8'h06
`define ADDR_PRIO_TWO     8'h07
`define ADDR_FLAGS_TWO    8'h08
`define ADDR_ENABLES_TWO  8'h09
`define ADDR_EE_VALUE     8'h0A
`define ADDR_EE_LOCATION  8'h0B
`define ADDR_STORE_OP     8'h0C
`define ADDR_FETCH_OP     8'h0D
`define ADDR_STATUS       8'h0E
`define UNLOCK_FIRST      8'h55
`define UNLOCK_SECOND     8'hAA
`define HOLD_RESET        8'hFF
`define ERASED_BYTE       8'hFF
`define PRIO_RESET        8'hFF
`define ROW_BYTES         64
`define BIT_FLASH_SEL     7
`define BIT_CFG_SEL       6
`define BIT_ROW_ERASE     4
`define BIT_INTERRUPTED   3
`define BIT_PROG_EN       2
`define BIT_GO            1
`define BIT_READ          0
`define BIT_DONE_FLAG     4
`define BIT_GIE           7
`define CTRL_MASK         8'hDF
`define LONG_WRITE_US     2000
`define CLOCK_MHZ         100
`define LONG_WRITE_CYCLES (`LONG_WRITE_US * `CLOCK_MHZ)
`endif

// File: rtl/flash_seq_pkg.sv
// Types shared by the flash block program sequencer
package flash_seq_pkg;
  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_GOT_FIRST,
    LOCK_OPEN
  } unlock_state_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_FLASH_PROG,
    OP_EE_WRITE
  } op_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage

// File: sim/flash_seq_assertions.sv
// Port-level assertions for the flash block program sequencer
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_seq_assertions #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       master_clear_pin,
  input wire logic       watchdog_expiry,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       cpu_stall,
  input wire logic       memory_done_flag
);
  logic [47:0] hist_reg;
  int          cnt_reg;
  logic        abort_reg;
  logic        clr_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Last three writes, newest in the low 16 bits
  always_ff @(posedge clock) begin
    if (srst) begin
      hist_reg  <= '0;
      cnt_reg   <= 0;
      abort_reg <= 1'b0;
      clr_reg   <= 1'b0;
    end else begin
      if (wr) hist_reg <= {hist_reg[31:0], addr, wdata};
      cnt_reg   <= cpu_stall ? cnt_reg + 1 : 0;
      abort_reg <= master_clear_pin | watchdog_expiry | abort_reg & cpu_stall;
      clr_reg   <= wr && addr == `ADDR_FLAGS_TWO;
    end
  end
  sequence s_ctrl_read;
    rd && addr == `ADDR_NVM_CONTROL;
  endsequence
  sequence s_timed_end;
    $fell(cpu_stall) && !abort_reg;
  endsequence
  property p_unlock_order;
    $rose(cpu_stall) |-> hist_reg[47:16] ==
      {`ADDR_UNLOCK, `UNLOCK_FIRST, `ADDR_UNLOCK, `UNLOCK_SECOND}
      && hist_reg[15:8] == `ADDR_NVM_CONTROL && hist_reg[`BIT_GO];
  endproperty
  a_unlock_order: assert property (p_unlock_order)
    else $error("stall began without the unlock sequence");
  property p_stall_len;
    s_timed_end |-> cnt_reg >= WRITE_CYCLES - 1 && cnt_reg <= WRITE_CYCLES + 1;
  endproperty
  a_stall_len: assert property (p_stall_len)
    else $error("long write length wrong");
  property p_stall_bound;
    cnt_reg <= WRITE_CYCLES + 1;
  endproperty
  a_stall_bound: assert property (p_stall_bound)
    else $error("stall outlasts the timer");
  property p_done_after;
    s_timed_end |-> ##[0:2] memory_done_flag;
  endproperty
  a_done_after: assert property (p_done_after)
    else $error("done flag missing after write");
  property p_done_holds;
    memory_done_flag && !clr_reg && !(wr && addr == `ADDR_FLAGS_TWO)
      |=> memory_done_flag;
  endproperty
  a_done_holds: assert property (p_done_holds)
    else $error("done flag dropped without software clear");
  property p_go_visible;
    s_ctrl_read ##0 cpu_stall |=> rdata[`BIT_GO] && rdata[`BIT_INTERRUPTED];
  endproperty
  a_go_visible: assert property (p_go_visible)
    else $error("go bit not seen during write");
  property p_unlock_reads;
    rd && addr == `ADDR_UNLOCK |=> rdata == 8'h00;
  endproperty
  a_unlock_reads: assert property (p_unlock_reads)
    else $error("unlock port read not zero");
  property p_rdata_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data without read");
endmodule
bind flash_block_program_sequencer flash_seq_assertions #(
  .WRITE_CYCLES(WRITE_CYCLES)
) flash_seq_assertions_inst (.clock(clock), .srst(srst),
  .master_clear_pin(master_clear_pin), .watchdog_expiry(watchdog_expiry),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .cpu_stall(cpu_stall), .memory_done_flag(memory_done_flag));

// File: sim/tb.sv
// Self-checking bench for the flash block program sequencer
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module tb;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       master_clear_pin = 1'b0;
  logic       watchdog_expiry = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       cpu_stall;
  logic       memory_done_flag;
  logic [7:0] img [8];
  int         failures = 0;
  int         total_checks = 0;
  always #5 clock = ~clock;
  flash_block_program_sequencer #(.WRITE_CYCLES(20))
    flash_block_program_sequencer_inst (.clock(clock), .srst(srst),
    .master_clear_pin(master_clear_pin), .watchdog_expiry(watchdog_expiry),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cpu_stall(cpu_stall), .memory_done_flag(memory_done_flag));
  task automatic give_verdict();
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic unlock_go(input logic [7:0] g);
    wreg(`ADDR_UNLOCK, `UNLOCK_FIRST);
    wreg(`ADDR_UNLOCK, `UNLOCK_SECOND);
    wreg(`ADDR_NVM_CONTROL, g);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (memory_done_flag !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    if (n == 500) begin
      failures++;
      give_verdict();
    end
    rchk(`ADDR_FLAGS_TWO, 8'h10);
    wreg(`ADDR_FLAGS_TWO, 8'h00);
  endtask
  task automatic load(input int i, input logic [7:0] d);
    wreg(`ADDR_PTR_LOW, 8'(i));
    wreg(`ADDR_BYTE_LATCH, d);
    wreg(`ADDR_STORE_OP, 8'h00);
  endtask
  task automatic prog();
    wreg(`ADDR_NVM_CONTROL, 8'h84);
    unlock_go(8'h86);
    wait_done();
  endtask
  // Fetch each byte of the block back through the latch
  task automatic vchk();
    for (int i = 0; i < 8; i++) begin
      wreg(`ADDR_PTR_LOW, 8'(i));
      wreg(`ADDR_FETCH_OP, 8'h00);
      rchk(`ADDR_BYTE_LATCH, img[i]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    rchk(`ADDR_PRIO_TWO, 8'hFF);
    rchk(`ADDR_NVM_CONTROL, 8'h00);
    rchk(`ADDR_UNLOCK, 8'h00);
    rchk(8'h3F, 8'h00);
    wreg(`ADDR_PTR_HIGH, 8'h01);
    wreg(`ADDR_PTR_UPPER, 8'h00);
    wreg(`ADDR_NVM_CONTROL, 8'h94);
    unlock_go(8'h96);
    wait_done();
    for (int i = 0; i < 8; i++) begin
      img[i] = 8'h50 + 8'(i);
      load(i, img[i]);
    end
    prog();
    vchk();
    load(0, 8'h0F);
    load(1, 8'hF0);
    img[0] = img[0] & 8'h0F;
    img[1] = img[1] & 8'hF0;
    prog();
    vchk();
    load(2, 8'h00);
    wreg(`ADDR_UNLOCK, `UNLOCK_FIRST);
    wreg(`ADDR_IRQ_CONTROL, 8'h00);
    wreg(`ADDR_UNLOCK, `UNLOCK_SECOND);
    wreg(`ADDR_NVM_CONTROL, 8'h86);
    #1 check({7'h00, cpu_stall}, 8'h00);
    rchk(`ADDR_NVM_CONTROL, 8'h84);
    wreg(`ADDR_NVM_CONTROL, 8'h80);
    unlock_go(8'h82);
    #1 check({7'h00, cpu_stall}, 8'h00);
    rchk(`ADDR_NVM_CONTROL, 8'h80);
    vchk();
    img[2] = 8'h00;
    prog();
    vchk();
    for (int s = 0; s < 2; s++) begin
      load(3, 8'h00);
      wreg(`ADDR_NVM_CONTROL, 8'h84);
      unlock_go(8'h86);
      rchk(`ADDR_NVM_CONTROL, 8'h8E);
      check({7'h00, cpu_stall}, 8'h01);
      rchk(`ADDR_STATUS, 8'h01);
      @(posedge clock);
      if (s == 0)
        master_clear_pin <= 1'b1;
      else
        watchdog_expiry <= 1'b1;
      repeat (3) @(posedge clock);
      master_clear_pin <= 1'b0;
      watchdog_expiry <= 1'b0;
      repeat (4) @(posedge clock);
      check({7'h00, cpu_stall}, 8'h00);
      check({7'h00, memory_done_flag}, 8'h00);
      rchk(`ADDR_NVM_CONTROL, 8'h88);
    end
    wreg(`ADDR_EE_LOCATION, 8'h10);
    for (int k = 0; k < 2; k++) begin
      wreg(`ADDR_EE_VALUE, k ? 8'hC3 : 8'h3C);
      wreg(`ADDR_NVM_CONTROL, 8'h04);
      unlock_go(8'h06);
      wait_done();
      wreg(`ADDR_EE_VALUE, 8'h00);
      wreg(`ADDR_NVM_CONTROL, 8'h01);
      rchk(`ADDR_EE_VALUE, k ? 8'hC3 : 8'h3C);
    end
    give_verdict();
  end
endmodule
